//--- logic/ast_pkg.sv
// Purpose: Constants and types for the asynchronous timer event block.
// Assumes: AXI4-Lite register port, 32-bit data, one clock.
// Notes: Bit positions inside registers are laid out here once.
package atm_pkg;
  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNTER = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_STCLR = 8'h0C;
  localparam logic [7:0] OFF_IRQEN = 8'h10;
  localparam logic [7:0] OFF_IRQDIS = 8'h14;
  localparam logic [7:0] OFF_IRQMASK = 8'h18;
  localparam logic [7:0] OFF_WAKE = 8'h1C;
  localparam logic [7:0] OFF_ALARM0 = 8'h20;
  localparam logic [7:0] OFF_ALARM1 = 8'h24;
  localparam logic [7:0] OFF_INTV0 = 8'h30;
  localparam logic [7:0] OFF_INTV1 = 8'h34;
  localparam logic [7:0] OFF_CLKCTL = 8'h40;
  localparam logic [7:0] OFF_CALENDAR_VALUE = 8'h54;
  localparam logic [7:0] OFF_PARAM = 8'hF0;
  localparam logic [7:0] OFF_VERSION = 8'hFC;
  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CTL_EN = 0;
  localparam int CTL_TAP_CHAIN_CLEAR = 1;
  localparam int CTL_CAL = 2;
  localparam int CTL_CA0 = 8;
  localparam int CTL_PSEL_LO = 16;
  localparam int CLK_CEN = 0;
  // Status / mask / clear / wake bit positions.
  localparam int ST_WRAP = 0;
  localparam int ST_MATCH0 = 8;
  localparam int ST_TICK0 = 16;
  localparam int ST_BUSY = 24;
  localparam int ST_READY = 25;
  localparam int ST_CLOCK_SYNC_PENDING = 28;
  localparam int ST_CLOCK_SYNC_DONE = 29;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] CNT_TOP = 32'hFFFF_FFFF;
  localparam logic [31:0] PARAM_VALUE = 32'h0000_0000;
  // Arbitrary neutral version code.
  localparam logic [31:0] VERSION_VALUE = 32'h0000_0100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Crossing length in cycles while busy.
  localparam logic [2:0] SYNC_CYCLES = 3'h4;
  localparam logic [2:0] CLKSYNC_CYCLES = 3'h4;
  typedef struct packed {
    logic wrap;
    logic tick;
    logic match;
    logic clock_sync_done;
    logic ready;
  } atm_irq_t;
  typedef enum logic [1:0] {
    SY_IDLE = 2'b00,
    SY_BUSY = 2'b01
  } atm_sync_t;
endpackage

//--- logic/atm_async_timer.sv
// What this block does
// - five separate interrupt request outputs
// - wrap flag on wrap or clearing match
// - clock-sync-done set on pending falling edge
// - register-sync-done set on busy falling edge
// - mask gates request; set/clear by ones
// - request holds until status-clear or mask-clear write
// - tick flag on selected prescaler bit rising
// - tick flag set only while enabled; tick request only when unmasked
// - match flag when counter equals alarm
// - clear-on-match clears counter, sets wrap
// - wake on enabled wrap, match, tick
// - wake ignores interrupt mask bits
// - wake holds until status-clear or wake-enable write
// - synced writes set busy, drop, read zero
// - crossing and busy always happen
// - tap select picks counter clocking bit
// - mode bit and enable bit decoding
// - prescaler clear write-one, reads zero
// - counter reads live, write loads value
// - clock pending from gate write to done
// - status-clear ones clear, ignored while busy
// - counter wraps all ones to zero
// - prescaler increments while enabled
//
// Purpose: Event, wake and write-crossing logic of the timer.
// Assumes: Prescaler clock equals the bus clock; crossing is modelled.
// Notes: The write crossing always takes SYNC_CYCLES cycles.
`timescale 1ns/10ps
module atm_async_timer (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output atm_pkg::atm_irq_t irq,
  output logic wake
);
  import atm_pkg::*;

  // ********************************************************************
  // Register state
  // ********************************************************************
  logic [31:0] ctl_q, cnt_q, alarm0_q, alarm1_q, intv0_q, intv1_q;
  logic [31:0] wakeEn_q, mask_q, clkCtl_q, calendar_value_q, pre_q, status_q;
  logic [31:0] pendData_q;
  logic [7:0] pendAddr_q;
  logic [2:0] syncCnt_q, clkCnt_q;
  atm_sync_t syncSt_q;
  logic busy, clock_sync_pending, busyDly_q, clkBusyDly_q;
  logic [1:0] tapPrev_q;
  logic cntTapPrev_q, wake_q;
  atm_irq_t irq_q;

  // AXI write capture: address and data accepted independently.
  logic awHave_q, wHave_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic wrFire, synced, wrOk;

  assign busy = (syncSt_q == SY_BUSY);
  assign clock_sync_pending = (clkCnt_q != 3'h0);
  assign wrFire = awHave_q && wHave_q && !bvalid;
  assign synced = (awAddr_q == OFF_CONTROL) || (awAddr_q == OFF_COUNTER)
    || (awAddr_q == OFF_STCLR) || (awAddr_q == OFF_WAKE)
    || (awAddr_q == OFF_ALARM0) || (awAddr_q == OFF_ALARM1)
    || (awAddr_q == OFF_INTV0) || (awAddr_q == OFF_INTV1)
    || (awAddr_q == OFF_CALENDAR_VALUE);
  assign wrOk = wrFire && !(synced && busy);

  // ********************************************************************
  // Bus write channel
  // ********************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= RESET_WORD;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= wdata;
      end
      if (wrFire)
      begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= RESP_OKAY;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end
  assign awready = !awHave_q && !bvalid;
  assign wready = !wHave_q && !bvalid;

  // ********************************************************************
  // Write crossing: busy window and the delayed commit
  // ********************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncSt_q <= SY_IDLE;
      syncCnt_q <= 3'h0;
      pendAddr_q <= 8'h00;
      pendData_q <= RESET_WORD;
    end
    else
    begin
      unique case (syncSt_q)
        SY_IDLE:
        begin
          // Even with one clock the crossing is kept, so software timing
          // is the same whatever the prescaler source.
          if (wrOk && synced)
          begin
            syncSt_q <= SY_BUSY;
            syncCnt_q <= SYNC_CYCLES;
            pendAddr_q <= awAddr_q;
            pendData_q <= wData_q;
          end
        end
        SY_BUSY:
        begin
          syncCnt_q <= syncCnt_q - 3'h1;
          if (syncCnt_q == 3'h1)
            syncSt_q <= SY_IDLE;
        end
      endcase
    end
  end
  logic commit;
  assign commit = busy && (syncCnt_q == 3'h1);

  // ********************************************************************
  // Configuration registers
  // ********************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl_q <= RESET_WORD;
      alarm0_q <= RESET_WORD;
      alarm1_q <= RESET_WORD;
      intv0_q <= RESET_WORD;
      intv1_q <= RESET_WORD;
      wakeEn_q <= RESET_WORD;
      calendar_value_q <= RESET_WORD;
    end
    else if (commit)
    begin
      unique case (pendAddr_q)
        OFF_CONTROL: ctl_q <= pendData_q & ~(32'h1 << CTL_TAP_CHAIN_CLEAR);
        OFF_ALARM0: alarm0_q <= pendData_q;
        OFF_ALARM1: alarm1_q <= pendData_q;
        OFF_INTV0: intv0_q <= pendData_q;
        OFF_INTV1: intv1_q <= pendData_q;
        OFF_WAKE: wakeEn_q <= pendData_q;
        OFF_CALENDAR_VALUE: calendar_value_q <= pendData_q;
        default: ctl_q <= ctl_q;
      endcase
    end
  end

  // Interrupt mask is not crossed: set/clear by ones right away.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mask_q <= RESET_WORD;
    else if (wrOk && awAddr_q == OFF_IRQEN)
      mask_q <= mask_q | wData_q;
    else if (wrOk && awAddr_q == OFF_IRQDIS)
      mask_q <= mask_q & ~wData_q;
  end

  // Clock control: a write that changes the gate bit starts a pending window.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clkCtl_q <= RESET_WORD;
      clkCnt_q <= 3'h0;
    end
    else if (wrOk && awAddr_q == OFF_CLKCTL && !clock_sync_pending)
    begin
      clkCtl_q <= wData_q;
      if (wData_q[CLK_CEN] != clkCtl_q[CLK_CEN])
        clkCnt_q <= CLKSYNC_CYCLES;
    end
    else if (clock_sync_pending)
      clkCnt_q <= clkCnt_q - 3'h1;
  end

  // ********************************************************************
  // Prescaler and counter
  // ********************************************************************
  logic en, pclrHit, cntTap, cntRise, match0, match1, clrMatch, wrapEv;
  logic [4:0] psel;
  logic [1:0] tapNow, tickEv;
  assign en = ctl_q[CTL_EN];
  assign psel = ctl_q[CTL_PSEL_LO +: 5];
  assign pclrHit = commit && pendAddr_q == OFF_CONTROL
    && pendData_q[CTL_TAP_CHAIN_CLEAR];
  assign cntTap = pre_q[psel];
  assign cntRise = en && cntTap && !cntTapPrev_q;
  assign match0 = en && (cnt_q == alarm0_q);
  assign match1 = en && (cnt_q == alarm1_q);
  assign clrMatch = (match0 && ctl_q[CTL_CA0])
    || (match1 && ctl_q[CTL_CA0 + 1]);
  // Counter mode wraps at all ones; calendar encoding is not modelled,
  // so calendar mode holds the written value unless a clear-on-match clears it.
  assign wrapEv = cntRise && !ctl_q[CTL_CAL] && (cnt_q == CNT_TOP);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pre_q <= RESET_WORD;
    else if (pclrHit)
      pre_q <= RESET_WORD;
    else if (en)
      pre_q <= pre_q + 32'h1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= RESET_WORD;
      cntTapPrev_q <= 1'b0;
    end
    else
    begin
      cntTapPrev_q <= cntTap;
      if (commit && pendAddr_q == OFF_COUNTER)
        cnt_q <= pendData_q;
      else if (clrMatch && cntRise)
        cnt_q <= RESET_WORD;
      else if (cntRise && !ctl_q[CTL_CAL])
        cnt_q <= cnt_q + 32'h1;
    end
  end

  // ********************************************************************
  // Event flags, requests and wake
  // ********************************************************************
  logic matchEv0, matchEv1, mPrev0_q, mPrev1_q, clr;
  logic [31:0] setV, clrV;
  assign matchEv0 = match0 && !mPrev0_q;
  assign matchEv1 = match1 && !mPrev1_q;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gTick
      logic [4:0] sel;
      assign sel = (g == 0) ? intv0_q[4:0] : intv1_q[4:0];
      assign tapNow[g] = pre_q[sel];
      assign tickEv[g] = en && tapNow[g] && !tapPrev_q[g];
    end
  endgenerate

  assign clr = commit && pendAddr_q == OFF_STCLR;
  always_comb
  begin
    setV = RESET_WORD;
    setV[ST_WRAP] = wrapEv || (clrMatch && (matchEv0 || matchEv1));
    setV[ST_MATCH0] = matchEv0;
    setV[ST_MATCH0 + 1] = matchEv1;
    setV[ST_TICK0 +: 2] = tickEv;
    setV[ST_READY] = busyDly_q && !busy;
    setV[ST_CLOCK_SYNC_DONE] = clkBusyDly_q && !clock_sync_pending;
    clrV = clr ? pendData_q : RESET_WORD;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_q <= RESET_WORD;
      tapPrev_q <= 2'b00;
      mPrev0_q <= 1'b0;
      mPrev1_q <= 1'b0;
      busyDly_q <= 1'b0;
      clkBusyDly_q <= 1'b0;
    end
    else
    begin
      // A new event wins over a clear in the same cycle.
      status_q <= (status_q & ~clrV) | setV;
      tapPrev_q <= tapNow;
      mPrev0_q <= match0;
      mPrev1_q <= match1;
      busyDly_q <= busy;
      clkBusyDly_q <= clock_sync_pending;
    end
  end

  logic [31:0] live;
  assign live = status_q & mask_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_q <= '0;
      wake_q <= 1'b0;
    end
    else
    begin
      irq_q.wrap <= live[ST_WRAP];
      irq_q.tick <= |live[ST_TICK0 +: 2];
      irq_q.match <= |live[ST_MATCH0 +: 2];
      irq_q.clock_sync_done <= live[ST_CLOCK_SYNC_DONE];
      irq_q.ready <= live[ST_READY];
      wake_q <= |(status_q & wakeEn_q
        & ~(32'hFFFF_FFFF << ST_BUSY));
    end
  end
  assign irq = irq_q;
  assign wake = wake_q;

  // ********************************************************************
  // Bus read channel
  // ********************************************************************
  logic [31:0] rdV;
  logic rdErr;
  always_comb
  begin
    rdV = RESET_WORD;
    rdErr = 1'b0;
    unique case ({araddr[7:2], 2'b00})
      OFF_CONTROL: rdV = ctl_q;
      OFF_COUNTER: rdV = cnt_q;
      OFF_STATUS:
      begin
        rdV = status_q;
        rdV[ST_BUSY] = busy;
        rdV[ST_CLOCK_SYNC_PENDING] = clock_sync_pending;
      end
      OFF_STCLR, OFF_IRQEN, OFF_IRQDIS: rdV = RESET_WORD;
      OFF_IRQMASK: rdV = mask_q;
      OFF_WAKE: rdV = wakeEn_q;
      OFF_ALARM0: rdV = alarm0_q;
      OFF_ALARM1: rdV = alarm1_q;
      OFF_INTV0: rdV = intv0_q;
      OFF_INTV1: rdV = intv1_q;
      OFF_CLKCTL: rdV = clkCtl_q;
      OFF_CALENDAR_VALUE: rdV = calendar_value_q;
      OFF_PARAM: rdV = PARAM_VALUE;
      OFF_VERSION: rdV = VERSION_VALUE;
      default: rdErr = 1'b1;
    endcase
    if (busy && araddr != OFF_STATUS && araddr != OFF_IRQMASK
        && araddr != OFF_CLKCTL)
      rdV = RESET_WORD;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid <= 1'b0;
      rdata <= RESET_WORD;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= rdV;
      rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end
  assign arready = !rvalid;

  // ********************************************************************
  // Checks
  // ********************************************************************
  AST_BUSY_LEN: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(busy) |-> busy [*4] ##1 !busy)
    else $error("Busy window length wrong.");
  AST_READY_SET: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(busy) |=> status_q[ST_READY])
    else $error("Ready flag not set after busy fell.");
  AST_CLOCK_SYNC_DONE_SET: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(clock_sync_pending) |=> status_q[ST_CLOCK_SYNC_DONE])
    else $error("Clock ready flag not set.");
  AST_WRAP_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
    wrapEv && !commit |=> cnt_q == RESET_WORD && status_q[ST_WRAP])
    else $error("Counter wrap wrong.");
  AST_IRQ_MASK: assert property (@(posedge clk) disable iff (!arst_n)
    irq.wrap |-> $past(status_q[ST_WRAP] && mask_q[ST_WRAP]))
    else $error("Wrap request without mask.");
  AST_DROP_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
    busy && wrFire && synced |=> $stable(pendData_q))
    else $error("Write taken while busy.");
  AST_TICK_SET: assert property (@(posedge clk) disable iff (!arst_n)
    tickEv[0] |=> status_q[ST_TICK0])
    else $error("Tick flag missed.");
  AST_WAKE_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    wake && !clr && !$past(clr) && !$changed(wakeEn_q) |=> wake)
    else $error("Wake dropped without clear.");
  AST_TAP_CHAIN_CLEAR_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
    !ctl_q[CTL_TAP_CHAIN_CLEAR])
    else $error("Prescaler clear bit stored.");
  COV_WRAP: cover property (@(posedge clk) disable iff (!arst_n) wrapEv);
  COV_MATCH: cover property (@(posedge clk) disable iff (!arst_n)
    matchEv0);
  COV_READY: cover property (@(posedge clk) disable iff (!arst_n)
    irq.ready);
endmodule

//--- test/tb_top.sv
// Purpose: Self-checking bench for the timer event and wake block.
// Assumes: Prescaler clock is the bus clock; bus reached over AXI4-Lite.
// Notes: Handshakes are sampled at the rising edge that completes them,
// before the design's flops update, and driven by non-blocking writes.
`timescale 1ns/10ps
module tb_top;
  import atm_pkg::*;
  // ********************************************************************
  // Design hookup
  // ********************************************************************
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  atm_irq_t irq;
  logic wake;
  logic [5:0] ev;
  int badCount = 0;
  int testsRun = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [7:0] zeroRegs [12] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1C,
    8'h20, 8'h24, 8'h30, 8'h34, 8'h40, 8'h54, 8'hF0};

  assign ev = {irq, wake};
  always #4 clk = ~clk;

  atm_async_timer dut (.clk(clk), .arst_n(arst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq), .wake(wake));

  // ********************************************************************
  // Bus tasks
  // ********************************************************************
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w)
    begin
      @(posedge clk);
      if (aw && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    bready <= 1'b1;
    @(posedge clk);
    while (bvalid !== 1'b1)
    begin
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge clk);
    while (arready !== 1'b1)
    begin
      @(posedge clk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    @(posedge clk);
    while (rvalid !== 1'b1)
    begin
      @(posedge clk);
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      badCount++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request levels are looked at one edge later, once they have settled.
  task automatic chkEv(input logic [5:0] sel, input logic [5:0] exp);
    @(posedge clk);
    chk32({26'h0, ev & sel}, {26'h0, exp});
  endtask

  // Read a register and compare only the bits under the mask.
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    axiRead(a, rd, rs);
    chk32(rd & m, exp);
  endtask

  // Waits for the crossing to end; a stuck busy is caught by the watchdog.
  task automatic waitIdle();
    rd = 32'hFFFF_FFFF;
    while (rd[ST_BUSY] !== 1'b0)
    begin
      axiRead(OFF_STATUS, rd, rs);
    end
  endtask

  task automatic wrIdle(input logic [7:0] a, input logic [31:0] d);
    axiWrite(a, d);
    waitIdle();
  endtask

  task automatic waitEv(input logic [5:0] sel, input int lim);
    int n;
    for (n = 0; n < lim && (ev & sel) == 6'h00; n++)
    begin
      @(posedge clk);
    end
  endtask

  task automatic conclude();
    if (badCount == 0 && testsRun > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ********************************************************************
  // Watchdog
  // ********************************************************************
  initial
  begin
    repeat (30000) @(posedge clk);
    badCount++;
    $display("MISMATCH %0t watchdog expired", $time);
    conclude();
  end

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (zeroRegs[i]) rdChk(zeroRegs[i], 32'hFFFF_FFFF, RESET_WORD);
    axiRead(8'h80, rd, rs);
    chk32({30'h0, rs}, {30'h0, RESP_SLVERR});
    // Crossing: read returns zero while busy, second write is dropped.
    axiWrite(OFF_ALARM1, 32'h0000_0005);
    axiWrite(OFF_ALARM1, 32'h0000_0007);
    waitIdle();
    rdChk(OFF_ALARM1, 32'hFFFF_FFFF, 32'h0000_0005);
    rdChk(OFF_STATUS, 32'h1 << ST_READY, 32'h1 << ST_READY);
    axiWrite(OFF_ALARM1, 32'h0000_0009);
    rdChk(OFF_ALARM1, 32'hFFFF_FFFF, 32'h0000_0000);
    axiWrite(OFF_WAKE, 32'h0000_0000);
    rdChk(OFF_STATUS, 32'h1 << ST_BUSY, 32'h1 << ST_BUSY);
    waitIdle();
    // Prescaler clear reads zero, mode bit reads back.
    wrIdle(OFF_CONTROL, 32'h0000_0006);
    rdChk(OFF_CONTROL, 32'hFFFF_FFFF, 32'h0000_0004);
    // Counter wrap with wake enabled and the wrap request masked.
    wrIdle(OFF_CONTROL, 32'h0000_0000);
    wrIdle(OFF_COUNTER, 32'hFFFF_FFF0);
    rdChk(OFF_COUNTER, 32'hFFFF_FFFF, 32'hFFFF_FFF0);
    wrIdle(OFF_WAKE, 32'h0000_0001);
    wrIdle(OFF_CONTROL, 32'h0000_0001);
    waitEv(6'h01, 200);
    chkEv(6'h01, 6'h01);
    chkEv(6'h20, 6'h00);
    rdChk(OFF_STATUS, 32'h1, 32'h1);
    axiRead(OFF_COUNTER, rd, rs);
    chk32({31'h0, rd < 32'h40}, 32'h1);
    axiWrite(OFF_IRQEN, 32'h0000_0001);
    chkEv(6'h20, 6'h20);
    rdChk(OFF_IRQMASK, 32'hFFFF_FFFF, 32'h0000_0001);
    axiWrite(OFF_IRQDIS, 32'h0000_0000);
    chkEv(6'h20, 6'h20);
    axiWrite(OFF_IRQDIS, 32'h0000_0001);
    chkEv(6'h20, 6'h00);
    axiWrite(OFF_IRQEN, 32'h0000_0001);
    wrIdle(OFF_CONTROL, 32'h0000_0000);
    wrIdle(OFF_STCLR, 32'h0000_0000);
    chkEv(6'h01, 6'h01);
    // The count passed both alarms and ticks ran, so clear all of them.
    wrIdle(OFF_STCLR, 32'h0003_0301);
    chkEv(6'h21, 6'h00);
    // Alarm with clear-on-match sets the wrap flag and clears the count.
    wrIdle(OFF_WAKE, 32'h0000_0000);
    wrIdle(OFF_COUNTER, 32'h0000_0000);
    wrIdle(OFF_ALARM0, 32'h0000_0014);
    axiWrite(OFF_IRQEN, 32'h0000_0100);
    wrIdle(OFF_CONTROL, 32'h0000_0101);
    waitEv(6'h08, 300);
    chkEv(6'h28, 6'h28);
    rdChk(OFF_STATUS, 32'h0000_0101, 32'h0000_0101);
    axiRead(OFF_COUNTER, rd, rs);
    chk32({31'h0, rd < 32'h15}, 32'h1);
    wrIdle(OFF_CONTROL, 32'h0000_0000);
    wrIdle(OFF_STCLR, 32'h0003_0301);
    chkEv(6'h28, 6'h00);
    // Periodic ticks on both channels; no tick request while disabled.
    wrIdle(OFF_INTV0, 32'h0000_0003);
    wrIdle(OFF_INTV1, 32'h0000_0002);
    axiWrite(OFF_IRQEN, 32'h0003_0000);
    repeat (40) @(posedge clk);
    chkEv(6'h10, 6'h00);
    wrIdle(OFF_WAKE, 32'h0003_0000);
    wrIdle(OFF_CONTROL, 32'h0000_0001);
    waitEv(6'h10, 100);
    chkEv(6'h10, 6'h10);
    repeat (40) @(posedge clk);
    rdChk(OFF_STATUS, 32'h0003_0000, 32'h0003_0000);
    chkEv(6'h01, 6'h01);
    wrIdle(OFF_CONTROL, 32'h0000_0000);
    // Clock gate handshake.
    axiWrite(OFF_CLKCTL, 32'h0000_0001);
    rdChk(OFF_STATUS, 32'h1 << ST_CLOCK_SYNC_PENDING, 32'h1 << ST_CLOCK_SYNC_PENDING);
    repeat (10) @(posedge clk);
    rdChk(OFF_STATUS, 32'h3 << ST_CLOCK_SYNC_PENDING, 32'h2 << ST_CLOCK_SYNC_PENDING);
    axiWrite(OFF_IRQEN, 32'h2200_0000);
    chkEv(6'h06, 6'h06);
    conclude();
  end
endmodule
